// file: gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [19:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [31:0] rdata_o,
  // Pins
  input  wire logic [7:0]  pin_i,
  output var  logic [7:0]  pin_o,
  output var  logic [7:0]  pin_oe_o,
  output var  logic [7:0]  pin_pullup_o,
  // Interrupt
  output var  logic        irq_o
);

  logic [7:0]  pin_pullup_enable_reg;
  logic [7:0]  pin_drive_enable_reg;
  logic [7:0]  pin_drive_level_reg;
  logic [7:0]  pin_sample_enable_reg;
  logic [7:0]  pin_sampled_level_reg;
  logic [23:0] pin_trigger_select_reg;
  logic        trigger_detect_enable_reg;
  logic [7:0]  port_pin_irq_flags_reg;
  logic [7:0]  irq_mask_reg;
  logic [31:0] rdata_next;
  logic        stat_rd;

  pin_event_if ev ();

  pin_event_detect u_detect (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ev      (ev.det)
  );

  // Feed the detector
  assign ev.trig_sel = pin_trigger_select_reg;
  assign ev.det_en   = trigger_detect_enable_reg;
  assign ev.level    = pin_sampled_level_reg;
  assign stat_rd     = rd_i && (addr_i == ADDR_IRQ_STAT);

  // Pull-up and drive enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_pullup_enable_reg <= BYTE_RESET;
      pin_drive_enable_reg  <= BYTE_RESET;
    end else if (wr_i && addr_i == ADDR_PULL_DRV) begin
      pin_pullup_enable_reg <= wdata_i[HI_FIELD_LSB +: 8];
      pin_drive_enable_reg  <= wdata_i[7:0];
    end
  end

  // Sample enables and drive levels
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sample_enable_reg <= BYTE_RESET;
      pin_drive_level_reg   <= BYTE_RESET;
    end else if (wr_i && addr_i == ADDR_SAMP_LVL) begin
      pin_sample_enable_reg <= wdata_i[HI_FIELD_LSB +: 8];
      pin_drive_level_reg   <= wdata_i[7:0];
    end
  end

  // Trigger selectors
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_trigger_select_reg <= TRIG_RESET;
    end else if (wr_i && addr_i == ADDR_TRIG_WAKE) begin
      pin_trigger_select_reg <= wdata_i[23:0];
    end
  end

  // Detect enable and interrupt mask
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trigger_detect_enable_reg <= 1'b0;
      irq_mask_reg              <= BYTE_RESET;
    end else if (wr_i) begin
      if (addr_i == ADDR_DET_CTRL) begin
        trigger_detect_enable_reg <= wdata_i[DET_EN_BIT];
      end
      if (addr_i == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wdata_i[7:0];
      end
    end
  end

  // Input sampling, gated per pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sampled_level_reg <= BYTE_RESET;
    end else begin
      pin_sampled_level_reg <= pin_i & pin_sample_enable_reg;
    end
  end

  // Sticky flags, set wins over read clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_pin_irq_flags_reg <= BYTE_RESET;
    end else begin
      port_pin_irq_flags_reg <= (stat_rd ? 8'h00 : port_pin_irq_flags_reg)
                                | ev.event_hit;
    end
  end

  // Pin drivers from registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o        <= BYTE_RESET;
      pin_oe_o     <= BYTE_RESET;
      pin_pullup_o <= BYTE_RESET;
    end else begin
      pin_o        <= pin_drive_level_reg;
      pin_oe_o     <= pin_drive_enable_reg;
      pin_pullup_o <= pin_pullup_enable_reg;
    end
  end

  // Interrupt level output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(port_pin_irq_flags_reg & irq_mask_reg);
    end
  end

  // Read mux
  always_comb begin
    rdata_next = WORD_ZERO;
    case (addr_i)
      ADDR_PULL_DRV: begin
        rdata_next = {8'h00, pin_pullup_enable_reg, 8'h00, pin_drive_enable_reg};
      end
      ADDR_SAMP_LVL: begin
        rdata_next = {8'h00, pin_sample_enable_reg, 8'h00, pin_drive_level_reg};
      end
      ADDR_IN_LEVEL: begin
        rdata_next = {24'h000000, pin_sampled_level_reg};
      end
      ADDR_TRIG_WAKE: begin
        rdata_next = {ev.wake_flag, pin_trigger_select_reg};
      end
      ADDR_IRQ_STAT: begin
        rdata_next = {24'h000000, port_pin_irq_flags_reg};
      end
      ADDR_IRQ_MASK: begin
        rdata_next = {24'h000000, irq_mask_reg};
      end
      ADDR_DET_CTRL: begin
        rdata_next = {31'h00000000, trigger_detect_enable_reg};
      end
      default: begin
        rdata_next = WORD_ZERO;
      end
    endcase
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= WORD_ZERO;
    end else begin
      rdata_o <= rd_i ? rdata_next : WORD_ZERO;
    end
  end

endmodule : gpio_port
`default_nettype wire

// file: gpio_pkg.sv
// Contract
// - Eight pins; bit n of every 8-bit per-pin field belongs to pin n only.
// - Control word zero bits 23:16 switch each pin's pull-up on or off.
// - Control word zero bits 7:0 enable each pin's output driver.
// - Control word one bits 7:0 give the level driven on enabled pins.
// - Control word one bits 23:16 enable each pin's input sampling.
// - Read-only level word returns registered levels of sampling-enabled pins, zero for the others; reads zero after reset.
// - Trigger word holds a 3-bit selector per pin at bits 3n+2:3n.
// - Condition flags 31:24 follow selector: zero, inverted, direct or change state.
// - Trigger detection acts only after the detect enable bit 0 is set.
// - A selected trigger sets that pin's sticky interrupt flag.
package gpio_pkg;

  localparam int          NUM_PINS       = 8;
  localparam int          ADDR_W         = 20;
  // Register byte addresses
  localparam logic [19:0] ADDR_PULL_DRV  = 20'h40800;
  localparam logic [19:0] ADDR_SAMP_LVL  = 20'h40804;
  localparam logic [19:0] ADDR_IN_LEVEL  = 20'h40808;
  localparam logic [19:0] ADDR_TRIG_WAKE = 20'h4080C;
  localparam logic [19:0] ADDR_IRQ_STAT  = 20'h40810;
  localparam logic [19:0] ADDR_IRQ_MASK  = 20'h40814;
  localparam logic [19:0] ADDR_DET_CTRL  = 20'h40818;
  // Field positions
  localparam int          HI_FIELD_LSB   = 16;
  localparam int          FLAG_FIELD_LSB = 24;
  localparam int          DET_EN_BIT     = 0;
  // Reset values
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [23:0] TRIG_RESET     = 24'h000000;
  localparam logic [31:0] WORD_ZERO      = 32'h00000000;

  typedef enum logic [2:0] {
    TRIG_OFF    = 3'h0,
    TRIG_RISE   = 3'h1,
    TRIG_FALL   = 3'h2,
    TRIG_CHANGE = 3'h3,
    TRIG_LOW_A  = 3'h4,
    TRIG_HIGH_A = 3'h5,
    TRIG_LOW_B  = 3'h6,
    TRIG_HIGH_B = 3'h7
  } trig_sel_t;

  // Selector of pin n from packed trigger field
  function automatic trig_sel_t sel_of(input logic [23:0] f, input int n);
    sel_of = trig_sel_t'(f[3*n +: 3]);
  endfunction : sel_of

endpackage : gpio_pkg

// file: pin_event_if.sv
`timescale 1ns/1ps
`default_nettype none
// Per-pin event path between detector and core
interface pin_event_if;
  import gpio_pkg::*;
  logic [23:0] trig_sel;
  logic        det_en;
  logic [7:0]  level;
  logic [7:0]  event_hit;
  logic [7:0]  wake_flag;
  modport det  (input trig_sel, det_en, level, output event_hit, wake_flag);
  modport core (output trig_sel, det_en, level, input event_hit, wake_flag);
endinterface : pin_event_if
`default_nettype wire

// file: pin_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Event path
  pin_event_if.det  ev
);

  logic [7:0] prev_reg;
  logic [7:0] change_reg;

  // Previous level for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= BYTE_RESET;
    end else begin
      prev_reg <= ev.level;
    end
  end

  // Change-detect state toggles on every level change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      change_reg <= BYTE_RESET;
    end else begin
      change_reg <= change_reg ^ (prev_reg ^ ev.level);
    end
  end

  // Hit and condition flag per pin
  always_comb begin
    ev.event_hit = 8'h00;
    ev.wake_flag = 8'h00;
    for (int n = 0; n < NUM_PINS; n++) begin
      case (sel_of(ev.trig_sel, n))
        TRIG_OFF: begin
          ev.wake_flag[n] = 1'b0;
        end
        TRIG_RISE: begin
          ev.event_hit[n] = ev.level[n] & ~prev_reg[n];
          ev.wake_flag[n] = ~ev.level[n];
        end
        TRIG_FALL: begin
          ev.event_hit[n] = ~ev.level[n] & prev_reg[n];
          ev.wake_flag[n] = ev.level[n];
        end
        TRIG_CHANGE: begin
          ev.event_hit[n] = ev.level[n] ^ prev_reg[n];
          ev.wake_flag[n] = change_reg[n];
        end
        TRIG_LOW_A, TRIG_LOW_B: begin
          ev.event_hit[n] = ~ev.level[n];
          ev.wake_flag[n] = ev.level[n];
        end
        TRIG_HIGH_A, TRIG_HIGH_B: begin
          ev.event_hit[n] = ev.level[n];
          ev.wake_flag[n] = ~ev.level[n];
        end
        default: begin
          ev.event_hit[n] = 1'b0;
        end
      endcase
      ev.event_hit[n] = ev.event_hit[n] & ev.det_en;
    end
  end

endmodule : pin_event_detect
`default_nettype wire

// file: gpio_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_assertions
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Register port
  input wire logic [19:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Pins and interrupt
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  pin_pullup_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Bus cycles to one address
  sequence s_wr(a); wr_i && addr_i == a; endsequence
  sequence s_rd(a); rd_i && addr_i == a; endsequence
  property p_drv_cfg;
    logic [31:0] v;
    (s_wr(ADDR_PULL_DRV), v = wdata_i) |-> ##2 pin_oe_o == v[7:0] && pin_pullup_o == v[23:16];
  endproperty
  a_drv_cfg: assert property (p_drv_cfg) else $error("drive or pull-up enable wrong");
  property p_out_level;
    logic [31:0] v;
    (s_wr(ADDR_SAMP_LVL), v = wdata_i) |-> ##2 pin_o == v[7:0];
  endproperty
  a_out_level: assert property (p_out_level) else $error("drive level wrong");
  property p_rd_quiet;
    !$past(rd_i) |-> rdata_o == WORD_ZERO;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read cycle");
  property p_lvl_upper;
    s_rd(ADDR_IN_LEVEL) |=> rdata_o[31:8] == 24'h000000;
  endproperty
  a_lvl_upper: assert property (p_lvl_upper) else $error("level word upper bits set");
  property p_mask_rd;
    rd_i && (addr_i == ADDR_PULL_DRV || addr_i == ADDR_SAMP_LVL)
      |=> rdata_o[31:24] == 8'h00 && rdata_o[15:8] == 8'h00;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask byte not zero");
  property p_trig_rb;
    logic [31:0] v;
    (s_wr(ADDR_TRIG_WAKE), v = wdata_i) ##1 s_rd(ADDR_TRIG_WAKE) |=> rdata_o[23:0] == v[23:0];
  endproperty
  a_trig_rb: assert property (p_trig_rb) else $error("trigger select readback wrong");
  property p_wake_zero;
    (wr_i && addr_i == ADDR_TRIG_WAKE && wdata_i[23:0] == TRIG_RESET) ##1 s_rd(ADDR_TRIG_WAKE)
      |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_wake_zero: assert property (p_wake_zero) else $error("flag set with trigger off");
  property p_mask_irq;
    wr_i && addr_i == ADDR_IRQ_MASK && wdata_i[7:0] == 8'h00 |-> ##2 !irq_o;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("interrupt while fully masked");
endmodule : gpio_port_assertions
bind gpio_port gpio_port_assertions chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .irq_o(irq_o));
`default_nettype wire

// file: pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  // Clock
  input  wire logic       clk_i,
  // Port side
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] pin_pullup_o,
  // External circuit
  input  wire logic [7:0] ext_drv_i,
  input  wire logic [7:0] ext_val_i,
  output var  logic [7:0] pin_i
);
  logic [7:0] float_reg = 8'h55;
  // Undriven, unpulled pins wander
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  // Port driver, then outside driver, then pull-up
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (pin_oe_o[n]) begin
        pin_i[n] = pin_o[n];
      end else if (ext_drv_i[n]) begin
        pin_i[n] = ext_val_i[n];
      end else begin
        pin_i[n] = pin_pullup_o[n] | float_reg[n];
      end
    end
  end
endmodule : pin_world
`default_nettype wire

// file: gpio_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_tb_top;
  import gpio_pkg::*;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, irq_o;
  logic [19:0] addr_i = 20'h00000;
  logic [31:0] wdata_i = 32'h00000000, rdata_o;
  logic [7:0]  pin_i, pin_o, pin_oe_o, pin_pullup_o, ext_drv = 8'h00, ext_val = 8'h00;
  int          failures = 0, comparisons = 0, cycles = 0;
  logic [19:0] regs [8] = '{ADDR_PULL_DRV, ADDR_SAMP_LVL, ADDR_IN_LEVEL, ADDR_TRIG_WAKE,
                            ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_DET_CTRL, 20'h40820};
  gpio_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o), .irq_o(irq_o));
  pin_world world (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .ext_drv_i(ext_drv), .ext_val_i(ext_val), .pin_i(pin_i));
  // Clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
  endtask : wr
  task rd(input logic [19:0] a, input logic [31:0] e);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(rdata_o, e);
  endtask : rd
  task idle(input int n);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(negedge clk_i);
  endtask : idle
  task pins(input logic [7:0] d, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    ext_drv <= d;
    ext_val <= v;
  endtask : pins
  task give_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(regs[i], WORD_ZERO);
    wr(ADDR_PULL_DRV, 32'hFFF0FF0F);
    wr(ADDR_SAMP_LVL, 32'hFFF0FF05);
    wr(ADDR_IN_LEVEL, 32'hFFFFFFFF);
    wr(20'h40820, 32'hFFFFFFFF);
    pins(8'h50, 8'h00);
    idle(3);
    check({24'h0, pin_oe_o}, 32'h0F);
    check({24'h0, pin_pullup_o}, 32'hF0);
    check({24'h0, pin_o}, 32'h05);
    rd(ADDR_PULL_DRV, 32'h00F0000F);
    rd(ADDR_SAMP_LVL, 32'h00F00005);
    rd(ADDR_IN_LEVEL, 32'h000000A0);
    rd(20'h40820, WORD_ZERO);
    wr(ADDR_IRQ_MASK, 32'h000000FF);
    wr(ADDR_TRIG_WAKE, 32'h00FAC688);
    rd(ADDR_TRIG_WAKE, 32'h02FAC688);
    idle(4);
    check({31'h0, irq_o}, 32'h0);
    wr(ADDR_DET_CTRL, 32'h00000001);
    idle(4);
    check({31'h0, irq_o}, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h000000F0);
    wr(ADDR_TRIG_WAKE, 32'h00008000);
    idle(2);
    rd(ADDR_IRQ_STAT, 32'h000000F0);
    rd(ADDR_IRQ_STAT, WORD_ZERO);
    pins(8'h70, 8'h00);
    pins(8'h50, 8'h00);
    idle(4);
    check({31'h0, irq_o}, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h00000020);
    wr(ADDR_IRQ_MASK, WORD_ZERO);
    pins(8'h70, 8'h00);
    pins(8'h50, 8'h00);
    idle(4);
    check({31'h0, irq_o}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h00000020);
    wr(ADDR_PULL_DRV, 32'h00F0000E);
    rd(ADDR_PULL_DRV, 32'h00F0000E);
    wr(ADDR_TRIG_WAKE, WORD_ZERO);
    rd(ADDR_TRIG_WAKE, WORD_ZERO);
    give_verdict();
  end
endmodule : gpio_port_tb_top
`default_nettype wire
